//--- logic/counter_array_pkg.sv
// constants for the counter array control and status register
package counter_array_pkg;
    localparam logic [7:0] CTRL_SFR_ADDR = 8'hD8;
    localparam logic [7:0] CTRL_SFR_PAGE = 8'h00;
    // bit addresses of the register are its byte address plus the bit number
    localparam logic [4:0] CTRL_BIT_BASE = 5'h1B;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int OVERFLOW_FLAG_POS = 7;
    localparam int RUN_BIT_POS = 6;
    localparam int MODULE5_FLAG_POS = 5;
    localparam int MODULE_COUNT = 6;
    localparam logic [7:0] FLAG_MASK = 8'hBF;
    localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
endpackage : counter_array_pkg

//--- logic/array_counter.sv
// shared 16-bit counter/timer of the counter array
`timescale 1ns/1ps
`default_nettype none
module array_counter (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic advance_in,
    output logic [15:0] count_out,
    output logic wrap_out
);
    import counter_array_pkg::*;

    // wrap marks the cycle whose advance takes the count from max to zero
    assign wrap_out = advance_in && (count_out == COUNTER_MAX);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_out <= COUNTER_RESET;
        end else if (advance_in) begin
            count_out <= count_out + 16'h0001;
        end
    end
endmodule : array_counter
`default_nettype wire

//--- logic/counter_array_control_flags.sv
// control and status register of the counter array, with its counter
`timescale 1ns/1ps
`default_nettype none
module counter_array_control_flags (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_page_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_bit_wr_in,
    input wire logic [7:0] sfr_bit_addr_in,
    input wire logic sfr_bit_val_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic timebase_tick_in,
    input wire logic [5:0] module_event_in,
    input wire logic [5:0] module_irq_enable_in,
    input wire logic overflow_interrupt_enable_in,
    input wire logic watchdog_enable_bit_in,
    output logic [15:0] counter_value_out,
    output logic array_irq_out,
    output logic watchdog_force_reset_out
);
    import counter_array_pkg::*;

    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] clear_mask;
    logic page_hit;
    logic byte_wr;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic advance;
    logic wrap;
    logic module5_write_one;

    // ************************************************************
    // register access
    // ************************************************************
    assign page_hit = (sfr_page_in == CTRL_SFR_PAGE);
    assign byte_wr = sfr_wr_in && page_hit && (sfr_addr_in == CTRL_SFR_ADDR);
    assign bit_wr = sfr_bit_wr_in && page_hit && (sfr_bit_addr_in[7:3] == CTRL_BIT_BASE);
    assign bit_sel = sfr_bit_addr_in[2:0];

    // bits that the current access tries to drive to zero
    always_comb begin
        clear_mask = 8'h00;
        if (byte_wr) begin
            clear_mask = ~sfr_wdata_in;
        end
        if (bit_wr && !sfr_bit_val_in) begin
            clear_mask[bit_sel] = 1'b1;
        end
    end

    // a single-bit write leaves the other seven bits alone
    always_comb begin
        next_ctrl = ctrl;
        if (byte_wr) begin
            next_ctrl = sfr_wdata_in;
        end
        if (bit_wr) begin
            next_ctrl[bit_sel] = sfr_bit_val_in;
        end
        // hardware set wins over a clear in the same cycle
        next_ctrl[OVERFLOW_FLAG_POS] = next_ctrl[OVERFLOW_FLAG_POS] | wrap;
        next_ctrl[5:0] = next_ctrl[5:0] | module_event_in;
    end

    // run bit keeps what software wrote, so it reads zero unless set
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            if (page_hit && (sfr_addr_in == CTRL_SFR_ADDR)) begin
                sfr_rdata_out <= ctrl;
            end else begin
                sfr_rdata_out <= 8'h00;
            end
        end
    end

    // ************************************************************
    // counter and watchdog effects
    // ************************************************************
    // the watchdog forces the counter on whatever the run bit says
    assign advance = timebase_tick_in
        && (ctrl[RUN_BIT_POS] || watchdog_enable_bit_in);

    array_counter counter_inst (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .advance_in(advance),
        .count_out(counter_value_out),
        .wrap_out(wrap)
    );

    assign module5_write_one = (byte_wr && sfr_wdata_in[MODULE5_FLAG_POS])
        || (bit_wr && (bit_sel == 3'(MODULE5_FLAG_POS)) && sfr_bit_val_in);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            watchdog_force_reset_out <= 1'b0;
        end else begin
            watchdog_force_reset_out <= watchdog_enable_bit_in && module5_write_one;
        end
    end

    // level request, combinational from the stored flags and enables
    assign array_irq_out = (ctrl[OVERFLOW_FLAG_POS] && overflow_interrupt_enable_in)
        || |(ctrl[5:0] & module_irq_enable_in);

    // ************************************************************
    // assertions
    // ************************************************************
    property p_overflow_sets;
        @(posedge clk_in) disable iff (rst_in)
        (advance && counter_value_out == COUNTER_MAX)
            |=> (ctrl[OVERFLOW_FLAG_POS] && counter_value_out == COUNTER_RESET);
    endproperty
    a_overflow_sets: assert property (p_overflow_sets)
        else $error("rollover missed overflow flag");

    property p_overflow_irq;
        @(posedge clk_in) disable iff (rst_in)
        $rose(ctrl[OVERFLOW_FLAG_POS]) && overflow_interrupt_enable_in |-> array_irq_out;
    endproperty
    a_overflow_irq: assert property (p_overflow_irq)
        else $error("overflow irq not raised");

    property p_run_counts;
        @(posedge clk_in) disable iff (rst_in)
        ctrl[RUN_BIT_POS] && timebase_tick_in
            |=> counter_value_out == $past(counter_value_out) + 16'h0001;
    endproperty
    a_run_counts: assert property (p_run_counts)
        else $error("running counter did not advance");

    property p_module_flag;
        @(posedge clk_in) disable iff (rst_in)
        module_event_in != 6'h00
            |=> (ctrl[5:0] & $past(module_event_in)) == $past(module_event_in);
    endproperty
    a_module_flag: assert property (p_module_flag)
        else $error("module event lost");

    // ties the event to the request, so it does not restate the irq expression
    property p_module_irq;
        @(posedge clk_in) disable iff (rst_in)
        (module_event_in & module_irq_enable_in) != 6'h00
            |=> array_irq_out || (($past(module_event_in) & module_irq_enable_in) == 6'h00);
    endproperty
    a_module_irq: assert property (p_module_irq)
        else $error("module irq not raised");

    property p_sticky;
        @(posedge clk_in) disable iff (rst_in)
        1'b1 |=> (($past(ctrl) & ~$past(clear_mask) & FLAG_MASK & ~ctrl) == 8'h00);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without a write");

    property p_bit_isolated;
        @(posedge clk_in) disable iff (rst_in)
        bit_wr && !byte_wr && wrap == 1'b0 && module_event_in == 6'h00
            |=> ((ctrl ^ $past(ctrl)) & ~(8'h01 << $past(bit_sel))) == 8'h00;
    endproperty
    a_bit_isolated: assert property (p_bit_isolated)
        else $error("bit write touched other bits");

    property p_watchdog_reset;
        @(posedge clk_in) disable iff (rst_in)
        watchdog_enable_bit_in && module5_write_one |=> watchdog_force_reset_out;
    endproperty
    a_watchdog_reset: assert property (p_watchdog_reset)
        else $error("watchdog reset not forced");

    property p_watchdog_runs;
        @(posedge clk_in) disable iff (rst_in)
        watchdog_enable_bit_in && timebase_tick_in && !ctrl[RUN_BIT_POS]
            |=> counter_value_out != $past(counter_value_out)
                && (!ctrl[RUN_BIT_POS] || $past(byte_wr || bit_wr));
    endproperty
    a_watchdog_runs: assert property (p_watchdog_runs)
        else $error("watchdog counter stalled");

    property p_stopped_holds;
        @(posedge clk_in) disable iff (rst_in)
        !ctrl[RUN_BIT_POS] && !watchdog_enable_bit_in
            |=> $stable(counter_value_out)
                && !($rose(ctrl[OVERFLOW_FLAG_POS]) && !$past(byte_wr || bit_wr));
    endproperty
    a_stopped_holds: assert property (p_stopped_holds)
        else $error("stopped counter moved");

    property p_read_data;
        @(posedge clk_in) disable iff (rst_in)
        sfr_rd_in && page_hit && sfr_addr_in == CTRL_SFR_ADDR
            |=> sfr_rdata_out == $past(ctrl);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("register read returned wrong data");

    property p_foreign_write;
        @(posedge clk_in) disable iff (rst_in)
        sfr_wr_in && !byte_wr && !bit_wr && !wrap && module_event_in == 6'h00
            |=> ctrl == $past(ctrl);
    endproperty
    a_foreign_write: assert property (p_foreign_write)
        else $error("write elsewhere changed the register");
endmodule : counter_array_control_flags
`default_nettype wire

//--- bench/sfr_host_model.sv
// cpu side model driving the special function register bus
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model
    import counter_array_pkg::*;
(
    input wire logic clk_in,
    output logic [7:0] addr_out,
    output logic [7:0] page_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out,
    output logic bit_wr_out,
    output logic [7:0] bit_addr_out,
    output logic bit_val_out
);
    initial begin
        {addr_out, page_out, wdata_out, bit_addr_out} = '0;
        {wr_out, rd_out, bit_wr_out, bit_val_out} = '0;
    end
    // idle data shows the inverse so a stale value never looks valid
    task automatic access(input logic [7:0] a, input logic [7:0] p, input logic w,
                          input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        page_out = p;
        wr_out = w;
        rd_out = !w;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = ~d;
    endtask : access
    task automatic bit_write(input logic [2:0] n, input logic v);
        @(negedge clk_in);
        page_out = CTRL_SFR_PAGE;
        bit_addr_out = CTRL_SFR_ADDR + {5'h00, n};
        bit_val_out = v;
        bit_wr_out = 1'b1;
        @(negedge clk_in);
        bit_wr_out = 1'b0;
        bit_val_out = ~v;
    endtask : bit_write
endmodule : sfr_host_model
`default_nettype wire

//--- bench/counter_array_control_flags_bench.sv
// self-checking bench for the counter array control register
`timescale 1ns/1ps
`default_nettype none
module counter_array_control_flags_bench;
    import counter_array_pkg::*;
    logic clk_in, rst_in, tick, ovf_en, wdog, wr, rd, bwr, bval, irq, wdr;
    logic [7:0] addr, page, wdata, baddr, rdata;
    logic [5:0] ev, ien;
    logic [15:0] cnt;
    int err_total, checks_done, wd_pulses;
    sfr_host_model i_host (.clk_in(clk_in), .addr_out(addr), .page_out(page), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata), .bit_wr_out(bwr), .bit_addr_out(baddr),
        .bit_val_out(bval));
    counter_array_control_flags i_dut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr),
        .sfr_page_in(page), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
        .sfr_bit_wr_in(bwr), .sfr_bit_addr_in(baddr), .sfr_bit_val_in(bval),
        .sfr_rdata_out(rdata), .timebase_tick_in(tick), .module_event_in(ev),
        .module_irq_enable_in(ien), .overflow_interrupt_enable_in(ovf_en),
        .watchdog_enable_bit_in(wdog), .counter_value_out(cnt), .array_irq_out(irq),
        .watchdog_force_reset_out(wdr));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) if (wdr === 1'b1) wd_pulses++;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic rd_reg(input logic [7:0] exp);
        i_host.access(CTRL_SFR_ADDR, CTRL_SFR_PAGE, 1'b0, 8'h00);
        check("register", {8'h00, exp}, {8'h00, rdata});
    endtask : rd_reg
    task automatic ticks(input int n);
        @(negedge clk_in);
        tick = 1'b1;
        repeat (n) @(negedge clk_in);
        tick = 1'b0;
    endtask : ticks
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #600000;
        err_total++;
        report_and_stop();
    end
    initial begin
        {tick, ovf_en, wdog, ev, ien} = '0;
        rst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        rd_reg(CTRL_RESET);
        i_host.access(8'hD9, CTRL_SFR_PAGE, 1'b1, 8'hFF);
        i_host.access(CTRL_SFR_ADDR, 8'h01, 1'b1, 8'hFF);
        rd_reg(8'h00);
        ticks(10);
        check("held counter", 16'h0000, cnt);
        i_host.access(CTRL_SFR_ADDR, CTRL_SFR_PAGE, 1'b1, 8'h40);
        ticks(20);
        check("counter", 16'h0014, cnt);
        $display("run gating test done");
        ovf_en = 1'b1;
        ticks(65535 - 20);
        check("before wrap irq", 16'h0000, {15'h0, irq});
        ticks(1);
        check("wrapped counter", 16'h0000, cnt);
        check("overflow irq", 16'h0001, {15'h0, irq});
        rd_reg(8'hC0);
        i_host.bit_write(3'd7, 1'b0);
        rd_reg(8'h40);
        i_host.access(CTRL_SFR_ADDR, CTRL_SFR_PAGE, 1'b1, 8'h00);
        $display("overflow test done");
        for (int i = 0; i < MODULE_COUNT; i++) begin
            @(negedge clk_in);
            ev[i] = 1'b1;
            @(negedge clk_in);
            ev = '0;
            repeat (3) @(negedge clk_in);
            rd_reg(8'h01 << i);
            check("masked irq", 16'h0000, {15'h0, irq});
            ien[i] = 1'b1;
            #1 check("module irq", 16'h0001, {15'h0, irq});
            i_host.bit_write(i[2:0], 1'b0);
            check("cleared irq", 16'h0000, {15'h0, irq});
            ien = '0;
        end
        @(negedge clk_in);
        ien[2] = 1'b1;
        ev[2] = 1'b1;
        @(negedge clk_in);
        ev = '0;
        check("event irq", 16'h0001, {15'h0, irq});
        i_host.bit_write(3'd2, 1'b0);
        check("event irq cleared", 16'h0000, {15'h0, irq});
        ien = '0;
        $display("module flag test done");
        i_host.bit_write(3'd5, 1'b1);
        repeat (3) @(negedge clk_in);
        check("unforced resets", 16'h0000, wd_pulses[15:0]);
        i_host.bit_write(3'd5, 1'b0);
        wdog = 1'b1;
        i_host.bit_write(3'd5, 1'b1);
        repeat (3) @(negedge clk_in);
        check("forced resets", 16'h0001, wd_pulses[15:0]);
        rd_reg(8'h20);
        i_host.bit_write(3'd5, 1'b0);
        ticks(5);
        check("forced counter", 16'h0005, cnt);
        rd_reg(8'h00);
        i_host.bit_write(3'd6, 1'b1);
        rd_reg(8'h40);
        i_host.bit_write(3'd6, 1'b0);
        ticks(3);
        check("counter after run writes", 16'h0008, cnt);
        $display("watchdog test done");
        report_and_stop();
    end
endmodule : counter_array_control_flags_bench
`default_nettype wire
